// ===== design/dtc_regs.vh
// Register addresses, field positions, encodings and reset values of the dual timer block
`ifndef DTC_REGS_VH
`define DTC_REGS_VH

// ****************************************************************
// Register addresses on the special function register port
// ****************************************************************
`define DTC_ADDR_CONTROL 8'h88
`define DTC_ADDR_MODE 8'h89
`define DTC_ADDR_A_LOW 8'h8a
`define DTC_ADDR_B_LOW 8'h8b
`define DTC_ADDR_A_HIGH 8'h8c
`define DTC_ADDR_B_HIGH 8'h8d
`define DTC_ADDR_CLOCK 8'h8e

// ****************************************************************
// Reset values
// ****************************************************************
`define DTC_RST_BYTE 8'h00
`define DTC_RST_MODE 2'h0

// ****************************************************************
// Timer clock control fields
// ****************************************************************
`define DTC_CK_AUX_B_HIGH 7
`define DTC_CK_AUX_B_LOW 6
`define DTC_CK_AUX_A_HIGH 5
`define DTC_CK_AUX_A_LOW 4
`define DTC_CK_TMR_B 3
`define DTC_CK_TMR_A 2
`define DTC_CK_DIV_HI 1
`define DTC_CK_DIV_LO 0

// ****************************************************************
// Timer control fields (low nibble is external interrupt logic, not here)
// ****************************************************************
`define DTC_TC_B_FLAG 7
`define DTC_TC_B_RUN 6
`define DTC_TC_A_FLAG 5
`define DTC_TC_A_RUN 4

// ****************************************************************
// Timer mode fields
// ****************************************************************
`define DTC_TM_B_GATE 7
`define DTC_TM_B_CNT 6
`define DTC_TM_B_MODE_HI 5
`define DTC_TM_B_MODE_LO 4
`define DTC_TM_A_GATE 3
`define DTC_TM_A_CNT 2
`define DTC_TM_A_MODE_HI 1
`define DTC_TM_A_MODE_LO 0

// ****************************************************************
// Operating modes
// ****************************************************************
`define DTC_MODE_13BIT 2'h0
`define DTC_MODE_16BIT 2'h1
`define DTC_MODE_RELOAD 2'h2
`define DTC_MODE_SPLIT 2'h3

// ****************************************************************
// Prescaler divider selects and ratios
// ****************************************************************
`define DTC_DIV_SEL_12 2'h0
`define DTC_DIV_SEL_4 2'h1
`define DTC_DIV_SEL_48 2'h2
`define DTC_DIV_SEL_EXT 2'h3
`define DTC_DIV_12_LAST 6'h0b
`define DTC_DIV_4_LAST 6'h03
`define DTC_DIV_48_LAST 6'h2f
`define DTC_DIV_EXT_LAST 3'h7

// ****************************************************************
// Counter constants
// ****************************************************************
`define DTC_BYTE_ALL_ONES 8'hff
`define DTC_LOW5_ALL_ONES 5'h1f
`define DTC_LOW5_ZERO 5'h00
`define DTC_ZERO_6 6'h00
`define DTC_ZERO_3 3'h0

`endif

// ===== design/dtc_fall_detect.v
// Two-stage synchroniser with a falling-edge pulse for one external input
module dtc_fall_detect (
    input wire clk, // System clock
    input wire reset, // Synchronous reset, active high
    input wire pin_in, // Asynchronous external level
    output reg fall_pulse // One-cycle pulse per high-to-low transition
);

    reg stage_one; // First synchroniser flop, read only by stage_two
    reg stage_two; // Second synchroniser flop
    reg stage_prev; // Previous synchronised sample

    // ****************************************************************
    // Synchronise, then compare consecutive settled samples
    // ****************************************************************
    // Resets to high, so a pin held low at release gives one falling-edge pulse
    always @(posedge clk) begin
        if (reset) begin
            stage_one <= 1'b1;
            stage_two <= 1'b1;
            stage_prev <= 1'b1;
            fall_pulse <= 1'b0;
        end else begin
            stage_one <= pin_in;
            stage_two <= stage_one;
            stage_prev <= stage_two;
            fall_pulse <= stage_prev & ~stage_two;
        end
    end

endmodule // dtc_fall_detect

// ===== design/dtc_dual_timer.v
// Two 16-bit counter/timers with shared prescaler and clock control register
`include "dtc_regs.vh"

module dtc_dual_timer (
    input wire clk, // System clock
    input wire reset, // Synchronous reset, active high
    input wire [7:0] sfr_addr, // Register address
    input wire [7:0] sfr_wdata, // Register write data
    input wire sfr_write, // Write strobe, one cycle
    input wire sfr_read, // Read strobe, one cycle
    output reg [7:0] sfr_rdata, // Read data, valid the cycle after sfr_read
    input wire count_pin_a, // External count input of timer A
    input wire count_pin_b, // External count input of timer B
    input wire ext_clock_in, // External oscillator clock, sampled
    input wire gate_input_a, // Gate input for timer A
    input wire gate_input_b, // Gate input for timer B
    input wire gate_a_polarity, // 1: gate A active high, 0: active low
    input wire gate_b_polarity, // 1: gate B active high, 0: active low
    input wire tmr_a_irq_enable, // Interrupt enable of timer A
    input wire tmr_b_irq_enable, // Interrupt enable of timer B
    input wire tmr_a_irq_ack, // Vector taken to timer A service, one cycle
    input wire tmr_b_irq_ack, // Vector taken to timer B service, one cycle
    output reg tmr_a_irq, // Timer A interrupt request, level
    output reg tmr_b_irq, // Timer B interrupt request, level
    output reg tmr_b_overflow, // Timer B overflow pulse for other peripherals
    output reg aux_a_low_clock_select, // Aux timer A low byte clock select
    output reg aux_a_high_clock_select, // Aux timer A high byte clock select
    output reg aux_b_low_clock_select, // Aux timer B low byte clock select
    output reg aux_b_high_clock_select // Aux timer B high byte clock select
);

    // ****************************************************************
    // Register state
    // ****************************************************************
    reg [7:0] timer_clock_control; // Clock control register
    reg [7:0] timer_mode_register; // Gate, counter select and mode fields
    reg tmr_a_run; // Timer A run bit
    reg tmr_b_run; // Timer B run bit
    reg tmr_a_overflow_flag; // Timer A sticky overflow
    reg tmr_b_overflow_flag; // Timer B sticky overflow
    reg [7:0] tmr_a_low_byte; // Timer A low byte
    reg [7:0] tmr_a_high_byte; // Timer A high byte
    reg [7:0] tmr_b_low_byte; // Timer B low byte
    reg [7:0] tmr_b_high_byte; // Timer B high byte
    reg [5:0] presc_count; // Internal prescaler divider
    reg [2:0] ext_count; // External clock divider
    reg presc_tick; // One-cycle prescaled clock enable

    // ****************************************************************
    // Field views
    // ****************************************************************
    wire [1:0] clock_divider_select; // Prescaler ratio
    wire tmr_a_clock_select; // 1: system clock for timer A
    wire tmr_b_clock_select; // 1: system clock for timer B
    wire tmr_a_gate_enable; // Timer A gate control
    wire tmr_b_gate_enable; // Timer B gate control
    wire tmr_a_counter_select; // Timer A counts pin edges
    wire tmr_b_counter_select; // Timer B counts pin edges
    wire [1:0] tmr_a_mode_field; // Timer A mode
    wire [1:0] tmr_b_mode_field; // Timer B mode
    wire pin_a_fall; // Synchronised falling edge of count pin A
    wire pin_b_fall; // Synchronised falling edge of count pin B
    wire ext_fall; // Synchronised falling edge of external clock

    assign clock_divider_select = timer_clock_control[`DTC_CK_DIV_HI:`DTC_CK_DIV_LO];
    assign tmr_a_clock_select = timer_clock_control[`DTC_CK_TMR_A];
    assign tmr_b_clock_select = timer_clock_control[`DTC_CK_TMR_B];
    assign tmr_a_gate_enable = timer_mode_register[`DTC_TM_A_GATE];
    assign tmr_b_gate_enable = timer_mode_register[`DTC_TM_B_GATE];
    assign tmr_a_counter_select = timer_mode_register[`DTC_TM_A_CNT];
    assign tmr_b_counter_select = timer_mode_register[`DTC_TM_B_CNT];
    assign tmr_a_mode_field = timer_mode_register[`DTC_TM_A_MODE_HI:`DTC_TM_A_MODE_LO];
    assign tmr_b_mode_field = timer_mode_register[`DTC_TM_B_MODE_HI:`DTC_TM_B_MODE_LO];

    // ****************************************************************
    // Input synchronisers
    // ****************************************************************
    // Pins must stay at each level two clocks so every edge is seen
    dtc_fall_detect u_sync_pin_a (
        .clk(clk),
        .reset(reset),
        .pin_in(count_pin_a),
        .fall_pulse(pin_a_fall)
    );

    dtc_fall_detect u_sync_pin_b (
        .clk(clk),
        .reset(reset),
        .pin_in(count_pin_b),
        .fall_pulse(pin_b_fall)
    );

    dtc_fall_detect u_sync_ext (
        .clk(clk),
        .reset(reset),
        .pin_in(ext_clock_in),
        .fall_pulse(ext_fall)
    );

    // ****************************************************************
    // Shared prescaler
    // ****************************************************************
    // Divider restarts its terminal count on the fly; a ratio change may give one short period
    reg [5:0] presc_last; // Terminal count for the selected ratio
    always @* begin
        case (clock_divider_select)
            `DTC_DIV_SEL_12: presc_last = `DTC_DIV_12_LAST;
            `DTC_DIV_SEL_4: presc_last = `DTC_DIV_4_LAST;
            default: presc_last = `DTC_DIV_48_LAST;
        endcase
    end

    // Tick generation for both internal and external sources
    always @(posedge clk) begin
        if (reset) begin
            presc_count <= `DTC_ZERO_6;
            ext_count <= `DTC_ZERO_3;
            presc_tick <= 1'b0;
        end else if (clock_divider_select == `DTC_DIV_SEL_EXT) begin
            presc_count <= `DTC_ZERO_6;
            if (ext_fall) begin
                ext_count <= ext_count + 3'h1;
            end
            presc_tick <= ext_fall && (ext_count == `DTC_DIV_EXT_LAST);
        end else begin
            ext_count <= `DTC_ZERO_3;
            if (presc_count >= presc_last) begin
                presc_count <= `DTC_ZERO_6;
                presc_tick <= 1'b1;
            end else begin
                presc_count <= presc_count + 6'h01;
                presc_tick <= 1'b0;
            end
        end
    end

    // ****************************************************************
    // Count enables
    // ****************************************************************
    wire a_split; // Timer A in split mode
    wire a_clk_tick; // Timer A timebase when counting clocks
    wire b_clk_tick; // Timer B timebase when counting clocks
    wire a_gate_open; // Gate A lets timer A run
    wire b_gate_open; // Gate B lets timer B run
    wire a_step; // Timer A (or its low byte) advances
    wire a_high_step; // Split high byte advances
    wire b_step; // Timer B advances

    assign a_split = (tmr_a_mode_field == `DTC_MODE_SPLIT);
    assign a_clk_tick = tmr_a_clock_select | presc_tick;
    assign b_clk_tick = tmr_b_clock_select | presc_tick;
    assign a_gate_open = ~tmr_a_gate_enable | (gate_input_a == gate_a_polarity);
    assign b_gate_open = ~tmr_b_gate_enable | (gate_input_b == gate_b_polarity);
    assign a_step = tmr_a_run & a_gate_open & (tmr_a_counter_select ? pin_a_fall : a_clk_tick);
    assign a_high_step = a_split & tmr_b_run & a_clk_tick;
    // With A split, B ignores its run bit and pin; mode 3 stops it either way
    assign b_step = (tmr_b_mode_field != `DTC_MODE_SPLIT) &
        (a_split ? b_clk_tick :
        (tmr_b_run & b_gate_open & (tmr_b_counter_select ? pin_b_fall : b_clk_tick)));

    // ****************************************************************
    // Next count values
    // ****************************************************************
    reg [7:0] next_a_low; // Timer A low byte after a step
    reg [7:0] next_a_high; // Timer A high byte after a step
    reg next_a_ovf; // Timer A wraps on this step
    reg [7:0] next_b_low; // Timer B low byte after a step
    reg [7:0] next_b_high; // Timer B high byte after a step
    reg next_b_ovf; // Timer B wraps on this step
    reg next_split_ovf; // Split high byte wraps

    // Timer A step; mode decode per its own field
    always @* begin
        next_a_low = tmr_a_low_byte;
        next_a_high = tmr_a_high_byte;
        next_a_ovf = 1'b0;
        next_split_ovf = (tmr_a_high_byte == `DTC_BYTE_ALL_ONES);
        case (tmr_a_mode_field)
            `DTC_MODE_13BIT: begin
                // Upper low-byte bits are left alone and read as whatever they hold
                next_a_low[4:0] = tmr_a_low_byte[4:0] + 5'h01;
                if (tmr_a_low_byte[4:0] == `DTC_LOW5_ALL_ONES) begin
                    next_a_high = tmr_a_high_byte + 8'h01;
                    next_a_ovf = (tmr_a_high_byte == `DTC_BYTE_ALL_ONES);
                end
            end
            `DTC_MODE_16BIT: begin
                next_a_low = tmr_a_low_byte + 8'h01;
                if (tmr_a_low_byte == `DTC_BYTE_ALL_ONES) begin
                    next_a_high = tmr_a_high_byte + 8'h01;
                    next_a_ovf = (tmr_a_high_byte == `DTC_BYTE_ALL_ONES);
                end
            end
            `DTC_MODE_RELOAD: begin
                next_a_ovf = (tmr_a_low_byte == `DTC_BYTE_ALL_ONES);
                next_a_low = next_a_ovf ? tmr_a_high_byte : tmr_a_low_byte + 8'h01;
            end
            default: begin
                next_a_low = tmr_a_low_byte + 8'h01;
                next_a_ovf = (tmr_a_low_byte == `DTC_BYTE_ALL_ONES);
                next_a_high = tmr_a_high_byte + 8'h01;
            end
        endcase
    end

    // Timer B step; mode 3 never reaches a step
    always @* begin
        next_b_low = tmr_b_low_byte;
        next_b_high = tmr_b_high_byte;
        next_b_ovf = 1'b0;
        case (tmr_b_mode_field)
            `DTC_MODE_13BIT: begin
                next_b_low[4:0] = tmr_b_low_byte[4:0] + 5'h01;
                if (tmr_b_low_byte[4:0] == `DTC_LOW5_ALL_ONES) begin
                    next_b_high = tmr_b_high_byte + 8'h01;
                    next_b_ovf = (tmr_b_high_byte == `DTC_BYTE_ALL_ONES);
                end
            end
            `DTC_MODE_16BIT: begin
                next_b_low = tmr_b_low_byte + 8'h01;
                if (tmr_b_low_byte == `DTC_BYTE_ALL_ONES) begin
                    next_b_high = tmr_b_high_byte + 8'h01;
                    next_b_ovf = (tmr_b_high_byte == `DTC_BYTE_ALL_ONES);
                end
            end
            `DTC_MODE_RELOAD: begin
                next_b_ovf = (tmr_b_low_byte == `DTC_BYTE_ALL_ONES);
                next_b_low = next_b_ovf ? tmr_b_high_byte : tmr_b_low_byte + 8'h01;
            end
            default: begin
                next_b_ovf = 1'b0;
            end
        endcase
    end

    // ****************************************************************
    // Flag set and clear terms
    // ****************************************************************
    wire a_flag_set; // Hardware sets timer A flag
    wire b_flag_set; // Hardware sets timer B flag
    wire ctl_write; // Write to the timer control register
    wire next_a_flag; // Timer A flag next value
    wire next_b_flag; // Timer B flag next value

    assign ctl_write = sfr_write && (sfr_addr == `DTC_ADDR_CONTROL);
    assign a_flag_set = a_step & next_a_ovf;
    // In split mode only the high byte of A may raise B's flag
    assign b_flag_set = a_split ? (a_high_step & next_split_ovf) : (b_step & next_b_ovf);
    // Set wins over software clear and over the vector acknowledge
    assign next_a_flag = a_flag_set | (~tmr_a_irq_ack &
        (ctl_write ? sfr_wdata[`DTC_TC_A_FLAG] : tmr_a_overflow_flag));
    assign next_b_flag = b_flag_set | (~tmr_b_irq_ack &
        (ctl_write ? sfr_wdata[`DTC_TC_B_FLAG] : tmr_b_overflow_flag));

    // ****************************************************************
    // Registers, counters and flags
    // ****************************************************************
    // A software write to a count byte takes precedence over a count in the same cycle
    always @(posedge clk) begin
        if (reset) begin
            timer_clock_control <= `DTC_RST_BYTE;
            timer_mode_register <= `DTC_RST_BYTE;
            tmr_a_run <= 1'b0;
            tmr_b_run <= 1'b0;
            tmr_a_overflow_flag <= 1'b0;
            tmr_b_overflow_flag <= 1'b0;
            tmr_a_low_byte <= `DTC_RST_BYTE;
            tmr_a_high_byte <= `DTC_RST_BYTE;
            tmr_b_low_byte <= `DTC_RST_BYTE;
            tmr_b_high_byte <= `DTC_RST_BYTE;
        end else begin
            tmr_a_overflow_flag <= next_a_flag;
            tmr_b_overflow_flag <= next_b_flag;
            if (ctl_write) begin
                // Run bits only gate counting; counts are untouched
                tmr_a_run <= sfr_wdata[`DTC_TC_A_RUN];
                tmr_b_run <= sfr_wdata[`DTC_TC_B_RUN];
            end
            if (sfr_write && (sfr_addr == `DTC_ADDR_MODE)) begin
                timer_mode_register <= sfr_wdata;
            end
            if (sfr_write && (sfr_addr == `DTC_ADDR_CLOCK)) begin
                timer_clock_control <= sfr_wdata;
            end
            // Timer A low byte
            if (sfr_write && (sfr_addr == `DTC_ADDR_A_LOW)) begin
                tmr_a_low_byte <= sfr_wdata;
            end else if (a_step) begin
                tmr_a_low_byte <= next_a_low;
            end
            // Timer A high byte: owned by A, or by the split high counter
            if (sfr_write && (sfr_addr == `DTC_ADDR_A_HIGH)) begin
                tmr_a_high_byte <= sfr_wdata;
            end else if (a_split ? a_high_step : a_step) begin
                tmr_a_high_byte <= next_a_high;
            end
            // Timer B bytes
            if (sfr_write && (sfr_addr == `DTC_ADDR_B_LOW)) begin
                tmr_b_low_byte <= sfr_wdata;
            end else if (b_step) begin
                tmr_b_low_byte <= next_b_low;
            end
            if (sfr_write && (sfr_addr == `DTC_ADDR_B_HIGH)) begin
                tmr_b_high_byte <= sfr_wdata;
            end else if (b_step) begin
                tmr_b_high_byte <= next_b_high;
            end
        end
    end

    // ****************************************************************
    // Registered outputs
    // ****************************************************************
    // Interrupt follows the flag value being stored, so both change on one edge
    always @(posedge clk) begin
        if (reset) begin
            tmr_a_irq <= 1'b0;
            tmr_b_irq <= 1'b0;
            tmr_b_overflow <= 1'b0;
            aux_a_low_clock_select <= 1'b0;
            aux_a_high_clock_select <= 1'b0;
            aux_b_low_clock_select <= 1'b0;
            aux_b_high_clock_select <= 1'b0;
            sfr_rdata <= `DTC_RST_BYTE;
        end else begin
            tmr_a_irq <= next_a_flag & tmr_a_irq_enable;
            tmr_b_irq <= next_b_flag & tmr_b_irq_enable;
            tmr_b_overflow <= b_step & next_b_ovf;
            aux_a_low_clock_select <= timer_clock_control[`DTC_CK_AUX_A_LOW];
            aux_a_high_clock_select <= timer_clock_control[`DTC_CK_AUX_A_HIGH];
            aux_b_low_clock_select <= timer_clock_control[`DTC_CK_AUX_B_LOW];
            aux_b_high_clock_select <= timer_clock_control[`DTC_CK_AUX_B_HIGH];
            // Read mux; unmapped addresses return zero
            if (!sfr_read) begin
                sfr_rdata <= `DTC_RST_BYTE;
            end else if (sfr_addr == `DTC_ADDR_CONTROL) begin
                sfr_rdata <= {tmr_b_overflow_flag, tmr_b_run, tmr_a_overflow_flag, tmr_a_run, 4'h0};
            end else if (sfr_addr == `DTC_ADDR_MODE) begin
                sfr_rdata <= timer_mode_register;
            end else if (sfr_addr == `DTC_ADDR_CLOCK) begin
                sfr_rdata <= timer_clock_control;
            end else if (sfr_addr == `DTC_ADDR_A_LOW) begin
                sfr_rdata <= tmr_a_low_byte;
            end else if (sfr_addr == `DTC_ADDR_A_HIGH) begin
                sfr_rdata <= tmr_a_high_byte;
            end else if (sfr_addr == `DTC_ADDR_B_LOW) begin
                sfr_rdata <= tmr_b_low_byte;
            end else if (sfr_addr == `DTC_ADDR_B_HIGH) begin
                sfr_rdata <= tmr_b_high_byte;
            end else begin
                sfr_rdata <= `DTC_RST_BYTE;
            end
        end
    end

endmodule // dtc_dual_timer

// ===== verif/dtc_checker.sv
// Port checks for the dual timer block
module dtc_checker (
    input wire clk, reset, sfr_write, sfr_read, // Clock, reset, strobes
    input wire [7:0] sfr_addr, sfr_wdata, sfr_rdata, // Register bus
    input wire tmr_a_irq_enable, tmr_b_irq_enable, tmr_a_irq, tmr_b_irq, // Interrupts
    input wire aux_a_low_clock_select, aux_a_high_clock_select, // Aux A selects
    input wire aux_b_low_clock_select, aux_b_high_clock_select // Aux B selects
);
    timeunit 1ns;
    timeprecision 1ps;
    wire [3:0] aux = {aux_b_high_clock_select, aux_b_low_clock_select, aux_a_high_clock_select, aux_a_low_clock_select};
    wire wr_ck = sfr_write && sfr_addr == 8'h8e; // Clock control write
    default clocking @(posedge clk); endclocking
    default disable iff (reset);
    a_rdata_idle: assert property (!$past(sfr_read) |-> sfr_rdata == 8'h00) else $error("rdata idle");
    // Register lands on the write edge and its output copy one edge later
    a_aux_write: assert property (wr_ck |=> ##1 aux == $past(sfr_wdata[7:4], 2))
        else $error("aux write");
    a_aux_hold: assert property (!$past(wr_ck) |=> $stable(aux)) else $error("aux hold");
    a_ck_readback: assert property (sfr_read && !wr_ck && sfr_addr == 8'h8e |=> sfr_rdata[7:4] == aux)
        else $error("clock readback");
    a_ctl_low: assert property (sfr_read && sfr_addr == 8'h88 |=> sfr_rdata[3:0] == 4'h0) else $error("ctl low");
    a_unmapped_zero: assert property (sfr_read && (sfr_addr < 8'h88 || sfr_addr > 8'h8e) |=> sfr_rdata == 8'h00)
        else $error("unmapped");
    a_irq_a_en: assert property (tmr_a_irq |-> tmr_a_irq_enable || $past(tmr_a_irq_enable)) else $error("irq a");
    a_irq_b_en: assert property ($rose(tmr_b_irq) |-> $past(tmr_b_irq_enable)) else $error("irq b");
endmodule // dtc_checker
bind dtc_dual_timer dtc_checker u_chk (.*);

// ===== verif/dtc_pin_model.sv
// Far-side model of the count pins and gate inputs
module dtc_pin_model (
    input wire clk, // System clock
    output logic count_pin_a = 1'b1, // Count pin A, idles high
    output logic count_pin_b = 1'b1, // Count pin B, idles high
    output logic gate_input_a = 1'b0, // Gate A level
    output logic gate_input_b = 1'b0 // Gate B level
);
    timeunit 1ns;
    timeprecision 1ps;
    // One falling edge; both levels held two cycles so the sampler cannot miss them
    task automatic pulse;
        count_pin_a = 0;
        repeat (2) @(negedge clk);
        count_pin_a = 1;
        repeat (2) @(negedge clk);
    endtask
endmodule // dtc_pin_model

// ===== verif/dual_timer_counter_with_prescaler_test.sv
// Self-checking bench of the dual timer block
module dual_timer_counter_with_prescaler_test;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk = 0, reset = 1, sfr_write = 0, sfr_read = 0, ext_clock_in = 0, gate_a_polarity = 1, gate_b_polarity = 1;
    logic tmr_a_irq_enable = 0, tmr_b_irq_enable = 0, tmr_a_irq_ack = 0, tmr_b_irq_ack = 0;
    logic [7:0] sfr_addr = 8'h00, sfr_wdata = 8'h00;
    wire [7:0] sfr_rdata;
    wire count_pin_a, count_pin_b, gate_input_a, gate_input_b, tmr_a_irq, tmr_b_irq, tmr_b_overflow;
    wire aux_a_low_clock_select, aux_a_high_clock_select, aux_b_low_clock_select, aux_b_high_clock_select;
    int n_mismatch = 0, total_checks = 0;
    always #12.5 clk = ~clk;
    // Free-running oscillator of four system clocks, changing on falling edges
    always #50 ext_clock_in = ~ext_clock_in;
    dtc_pin_model u_pins (.*);
    dtc_dual_timer u_dut (.*);
    task automatic chk(input logic [7:0] got, exp);
        total_checks++;
        if (got !== exp) begin
            n_mismatch++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [7:0] a, d);
        sfr_addr = a;
        sfr_wdata = d;
        sfr_write = 1;
        @(negedge clk) sfr_write = 0;
        @(negedge clk);
    endtask
    // Data lands on the read edge and is checked half a cycle later
    task automatic rd(input logic [7:0] a, e, m = 8'hff);
        sfr_addr = a;
        sfr_read = 1;
        @(negedge clk) sfr_read = 0;
        chk(sfr_rdata & m, e);
        @(negedge clk);
    endtask
    task automatic wait_irq(input logic b);
        for (int i = 0; i < 200 && (b ? tmr_b_irq : tmr_a_irq) !== 1'b1; i++) @(negedge clk);
        chk(b ? tmr_b_irq : tmr_a_irq, 8'h01);
    endtask
    task automatic reg_map;
        wr(8'h8f, 8'hff);
        for (int a = 8'h88; a <= 8'h8f; a++) rd(a[7:0], 8'h00);
        wr(8'h8e, 8'hf6);
        rd(8'h8e, 8'hf6);
    endtask
    // Modes 0 to 2 off the /48 prescaler, each preloaded to wrap on its first step
    task automatic mode_wraps;
        tmr_a_irq_enable = 1;
        wr(8'h8e, 8'h02);
        for (int m = 0; m < 3; m++) begin
            wr(8'h89, m[7:0]);
            wr(8'h8a, 8'hff);
            wr(8'h8c, m == 2 ? 8'h80 : 8'hff);
            wr(8'h88, 8'h10);
            wait_irq(0);
            wr(8'h88, 8'h00);
            rd(8'h8a, m == 2 ? 8'h80 : 8'h00, m == 0 ? 8'h1f : 8'hff);
            rd(8'h8c, m == 2 ? 8'h80 : 8'h00);
        end
    endtask
    task automatic edge_count;
        wr(8'h8a, 8'h00);
        wr(8'h89, 8'h0d);
        wr(8'h88, 8'h10);
        u_pins.pulse;
        u_pins.gate_input_a = 1;
        repeat (2) u_pins.pulse;
        repeat (6) @(negedge clk);
        rd(8'h8a, 8'h02);
    endtask
    task automatic split_mode;
        tmr_b_irq_enable = 1;
        wr(8'h88, 8'h00);
        wr(8'h8e, 8'h04);
        wr(8'h8c, 8'hf0);
        wr(8'h8d, 8'hfe);
        wr(8'h8b, 8'hff);
        wr(8'h89, 8'h23);
        wr(8'h88, 8'h40);
        wait_irq(1);
        rd(8'h88, 8'hc0);
        tmr_b_irq_ack = 1;
        @(negedge clk) tmr_b_irq_ack = 0;
        @(negedge clk) chk(tmr_b_irq, 8'h00);
        // B reloads every 24 clocks; its own wrap pulses out but leaves the flag alone
        wr(8'h88, 8'h00);
        for (int i = 0; i < 100 && tmr_b_overflow !== 1'b1; i++) @(negedge clk);
        chk(tmr_b_overflow, 8'h01);
        rd(8'h88, 8'h00);
        wr(8'h89, 8'h33);
        wr(8'h8b, 8'h55);
        repeat (30) @(negedge clk);
        rd(8'h8b, 8'h55);
    endtask
    // Gap between two wraps of a 0xff reload, less the two cycles of the clearing write
    task automatic presc_ratio;
        int n;
        wr(8'h89, 8'h02);
        wr(8'h8a, 8'hff);
        wr(8'h8c, 8'hff);
        for (int s = 0; s < 4; s++) begin
            wr(8'h8e, s[7:0]);
            wr(8'h88, 8'h10);
            wait_irq(0);
            wr(8'h88, 8'h10);
            for (n = 0; n < 100 && tmr_a_irq !== 1'b1; n++) @(negedge clk);
            chk(n[7:0], s == 0 ? 8'h0a : s == 1 ? 8'h02 : s == 2 ? 8'h2e : 8'h1e);
            wr(8'h88, 8'h00);
        end
    endtask
    task automatic complete_run;
        $display("Checks %0d mismatches %0d", total_checks, n_mismatch);
        if (n_mismatch == 0 && total_checks > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask
    initial begin
        repeat (8) @(negedge clk);
        reset = 0;
        reg_map;
        mode_wraps;
        edge_count;
        split_mode;
        presc_ratio;
        complete_run;
    end
    initial begin
        #500us;
        n_mismatch++;
        complete_run;
    end
endmodule // dual_timer_counter_with_prescaler_test
